// file: inc/maf_defs.svh
// register map, field positions, reset values and timing constants
// Overview of operation
// (R1) with deferral checking on, a held-off transmitter stops deferring after 10,000 bit times.
// (R2) the deferral timer restarts from zero each time a post-collision back-off finishes.
// (R3) with deferral checking off, the transmitter defers for as long as the medium is busy.
// (R4) frames leave the transmit buffer only while transmitter_enable is set.
// (R5) arriving frames are taken from the PHY only while the receive enable is set.
// (R6) station_address_high holds address bits 47:32 in its low half; the upper half is reserved.
// (R7) station_address_low holds address bits 31:0 across its whole width.
// (R8) a programmed configuration memory found at power-on loads both station address registers.
// (R9) memory bytes 0x01-0x04 fill station_address_low LSB first; 0x05 and 0x06 fill the high half.
// (R10) address low bits 7:0 is the first byte on the wire, up to high bits 15:8 as the sixth.
// (R11) software overwrites the station address only after power-on loading has completed; the block does not enforce this and accepts host writes at any time.
// (R12) a six-bit hash index picks high or low hash register by its top bit, then the bit.
// (R13) a multicast frame is accepted when the selected hash bit is one, else rejected.
// (R14) with pass_all_multicast set, every multicast frame is accepted.
// (R15) multicast_hash_high holds table bits 63:32 and multicast_hash_low bits 31:0.
// (R16) the hash index is the top six bits of the CRC-32 over the destination address.
`ifndef MAF_DEFS_SVH
`define MAF_DEFS_SVH

// register indices
`define MAF_IDX_CTRL 4'h1
`define MAF_IDX_ADDR_HI 4'h2
`define MAF_IDX_ADDR_LO 4'h3
`define MAF_IDX_HASH_HI 4'h4
`define MAF_IDX_HASH_LO 4'h5
`define MAF_IDX_STATUS 4'h9

// reset values
`define MAF_RST_ADDR_HI 16'hFFFF
`define MAF_RST_ADDR_LO 32'h0FFFFFFF
`define MAF_RST_HASH 32'h00000000
`define MAF_RST_CTRL 4'h4

// control bits
`define MAF_CTRL_RX_EN 0
`define MAF_CTRL_TX_EN 1
`define MAF_CTRL_DEFER_CHK 2
`define MAF_CTRL_PASS_MC 3

// status bits
`define MAF_STAT_INIT 0
`define MAF_STAT_DEFER 1
`define MAF_STAT_EXCESS 2

// configuration memory byte locations
`define MAF_EE_FIRST 8'h01
`define MAF_EE_LAST 8'h06
`define MAF_EE_LO_BYTES 3'h4

// deferral limit
`define MAF_DEFER_BITS 10000
`define MAF_BIT_TIME_NS 10
`define MAF_CLK_NS 4
`define MAF_DEFER_CYC ((`MAF_DEFER_BITS * `MAF_BIT_TIME_NS + `MAF_CLK_NS - 1) / `MAF_CLK_NS)

// crc and address framing
`define MAF_CRC_POLY 32'hEDB88320
`define MAF_CRC_INIT 32'hFFFFFFFF
`define MAF_DA_BYTES 3'h6

`endif

// file: inc/maf_pkg.sv
// shared types of the address filter and configuration block
package maf_pkg;

    // transmit deferral states
    typedef enum logic [3:0] {
        MAF_DF_IDLE = 4'b0001,
        MAF_DF_WAIT = 4'b0010,
        MAF_DF_GO = 4'b0100,
        MAF_DF_SEND = 4'b1000
    } maf_defer_state_t;

endpackage

// file: rtl/maf_defer.sv
// transmit deferral timer and start control
`include "maf_defs.svh"
module maf_defer
    import maf_pkg::*;
#(
    parameter int DEFER_CYC = `MAF_DEFER_CYC,
    parameter int CNT_W = $clog2(DEFER_CYC + 1)
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // control
    input wire logic tx_enable,
    input wire logic defer_check,
    // transmit path
    input wire logic tx_req,
    input wire logic medium_busy,
    input wire logic backoff_done,
    input wire logic tx_done,
    output logic tx_start,
    output logic deferring,
    output logic defer_timeout
);
    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(DEFER_CYC - 1);

    maf_defer_state_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic start_d, to_d;

    // next state of deferral
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        to_d = 1'b0;
        unique case (st_q)
            MAF_DF_IDLE:
            begin
                cnt_d = '0;
                if (tx_req && tx_enable) // R4
                    st_d = MAF_DF_WAIT;
            end
            MAF_DF_WAIT:
            begin
                if (!tx_enable) // R4
                    st_d = MAF_DF_IDLE;
                else if (!medium_busy)
                    st_d = MAF_DF_GO;
                else if (defer_check && cnt_q == LIMIT) // R1
                begin
                    st_d = MAF_DF_GO;
                    to_d = 1'b1;
                end
                else if (defer_check)
                    cnt_d = cnt_q + 1'b1;
                // without checking the wait has no limit R3
            end
            MAF_DF_GO:
                st_d = MAF_DF_SEND;
            MAF_DF_SEND:
            begin
                if (backoff_done) // R2
                begin
                    cnt_d = '0;
                    st_d = MAF_DF_WAIT;
                end
                else if (tx_done)
                    st_d = MAF_DF_IDLE;
            end
        endcase
        start_d = (st_d == MAF_DF_GO);
    end

    // deferral registers
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            st_q <= MAF_DF_IDLE;
            cnt_q <= '0;
            tx_start <= 1'b0;
            deferring <= 1'b0;
            defer_timeout <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            tx_start <= start_d;
            deferring <= (st_d == MAF_DF_WAIT);
            defer_timeout <= to_d;
        end
    end

endmodule // maf_defer

// file: rtl/maf_hash.sv
// destination address filter: perfect match and multicast hash
`include "maf_defs.svh"
module maf_hash
    import maf_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // configuration
    input wire logic rx_enable,
    input wire logic pass_all_multicast,
    input wire logic [47:0] station_addr,
    input wire logic [63:0] hash_table,
    // receive byte stream
    input wire logic rx_sof,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    // verdict
    output logic rx_accept,
    output logic rx_reject
);
    logic [31:0] crc_q, crc_d;
    logic [2:0] cnt_q, cnt_d;
    logic mc_q, mc_d, eq_q, eq_d, acc_d, rej_d;
    logic [5:0] idx;

    // one byte of reflected crc-32
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ `MAF_CRC_POLY) : (r >> 1);
        return r;
    endfunction

    // byte walk through the destination address
    always_comb
    begin
        crc_d = crc_q;
        cnt_d = cnt_q;
        mc_d = mc_q;
        eq_d = eq_q;
        acc_d = 1'b0;
        rej_d = 1'b0;
        idx = '0;
        if (rx_enable && rx_valid && (rx_sof || cnt_q != '0)) // R5
        begin
            crc_d = crc_byte(rx_sof ? `MAF_CRC_INIT : crc_q, rx_data);
            // first wire byte meets address bits 7:0 R10
            if (rx_sof)
            begin
                mc_d = rx_data[0];
                eq_d = (rx_data == station_addr[7:0]);
                cnt_d = 3'h1;
            end
            else
            begin
                eq_d = eq_q && (rx_data == station_addr[8*cnt_q +: 8]);
                cnt_d = cnt_q + 3'h1;
            end
            idx = crc_d[31:26]; // R16
            if (cnt_d == `MAF_DA_BYTES)
            begin
                cnt_d = '0;
                if (mc_d)
                    acc_d = pass_all_multicast || hash_table[idx]; // R12 R13 R14
                else
                    acc_d = eq_d;
                rej_d = !acc_d;
            end
        end
    end

    // filter registers
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            crc_q <= `MAF_CRC_INIT;
            cnt_q <= '0;
            mc_q <= 1'b0;
            eq_q <= 1'b0;
            rx_accept <= 1'b0;
            rx_reject <= 1'b0;
        end
        else
        begin
            crc_q <= crc_d;
            cnt_q <= cnt_d;
            mc_q <= mc_d;
            eq_q <= eq_d;
            rx_accept <= acc_d;
            rx_reject <= rej_d;
        end
    end

endmodule // maf_hash

// file: rtl/maf_top.sv
// mac address filter and configuration block with register port
`include "maf_defs.svh"
module maf_top
    import maf_pkg::*;
#(
    parameter int DEFER_CYC = `MAF_DEFER_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // configuration memory loader
    input wire logic ee_present,
    input wire logic ee_valid,
    input wire logic [7:0] ee_addr,
    input wire logic [7:0] ee_data,
    input wire logic ee_done,
    // transmit side
    input wire logic tx_req,
    input wire logic medium_busy,
    input wire logic backoff_done,
    input wire logic tx_done,
    output logic tx_start,
    // receive side
    input wire logic rx_sof,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_accept,
    output logic rx_reject,
    // state
    output logic init_done
);
    logic [15:0] addr_hi_q, addr_hi_d;
    logic [31:0] addr_lo_q, addr_lo_d;
    logic [31:0] hash_hi_q, hash_hi_d;
    logic [31:0] hash_lo_q, hash_lo_d;
    logic [3:0] ctrl_q, ctrl_d;
    logic init_q, init_d;
    logic excess_q, excess_d;
    logic [31:0] rdata_d;
    logic [31:0] status;
    logic [7:0] ee_off;
    logic ee_hit;
    logic deferring, defer_timeout;

    // configuration memory byte position
    assign ee_off = ee_addr - `MAF_EE_FIRST;
    assign ee_hit = ee_present && ee_valid && !init_q
        && ee_addr >= `MAF_EE_FIRST && ee_addr <= `MAF_EE_LAST; // R8

    // status word
    always_comb
    begin
        status = '0;
        status[`MAF_STAT_INIT] = init_q;
        status[`MAF_STAT_DEFER] = deferring;
        status[`MAF_STAT_EXCESS] = excess_q;
    end

    // next values of the register file
    always_comb
    begin
        addr_hi_d = addr_hi_q;
        addr_lo_d = addr_lo_q;
        hash_hi_d = hash_hi_q;
        hash_lo_d = hash_lo_q;
        ctrl_d = ctrl_q;
        init_d = init_q || ee_done;
        excess_d = excess_q;
        // host writes; the loader is expected done first R11
        if (reg_wr)
        begin
            unique case (reg_addr)
                `MAF_IDX_CTRL: ctrl_d = reg_wdata[3:0];
                `MAF_IDX_ADDR_HI: addr_hi_d = reg_wdata[15:0]; // R6
                `MAF_IDX_ADDR_LO: addr_lo_d = reg_wdata; // R7
                `MAF_IDX_HASH_HI: hash_hi_d = reg_wdata; // R15
                `MAF_IDX_HASH_LO: hash_lo_d = reg_wdata; // R15
                `MAF_IDX_STATUS:
                    if (reg_wdata[`MAF_STAT_EXCESS])
                        excess_d = 1'b0;
                default: ;
            endcase
        end
        // timeout event wins over a clear in the same cycle
        if (defer_timeout)
            excess_d = 1'b1;
        // power-on load of station address, lsb first R9
        if (ee_hit)
        begin
            if (ee_off[2:0] < `MAF_EE_LO_BYTES)
                addr_lo_d[8*ee_off[1:0] +: 8] = ee_data;
            else
                addr_hi_d[8*ee_off[0] +: 8] = ee_data;
        end
    end

    // read mux, answer in the next cycle
    always_comb
    begin
        rdata_d = '0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `MAF_IDX_CTRL: rdata_d = {28'h0000000, ctrl_q};
                `MAF_IDX_ADDR_HI: rdata_d = {16'h0000, addr_hi_q}; // R6
                `MAF_IDX_ADDR_LO: rdata_d = addr_lo_q; // R7
                `MAF_IDX_HASH_HI: rdata_d = hash_hi_q;
                `MAF_IDX_HASH_LO: rdata_d = hash_lo_q;
                `MAF_IDX_STATUS: rdata_d = status;
                default: rdata_d = '0;
            endcase
        end
    end

    // register file flops
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            addr_hi_q <= `MAF_RST_ADDR_HI;
            addr_lo_q <= `MAF_RST_ADDR_LO;
            hash_hi_q <= `MAF_RST_HASH;
            hash_lo_q <= `MAF_RST_HASH;
            ctrl_q <= `MAF_RST_CTRL;
            init_q <= 1'b0;
            excess_q <= 1'b0;
            reg_rdata <= '0;
            init_done <= 1'b0;
        end
        else
        begin
            addr_hi_q <= addr_hi_d;
            addr_lo_q <= addr_lo_d;
            hash_hi_q <= hash_hi_d;
            hash_lo_q <= hash_lo_d;
            ctrl_q <= ctrl_d;
            init_q <= init_d;
            excess_q <= excess_d;
            reg_rdata <= rdata_d;
            init_done <= init_d;
        end
    end

    // transmit deferral
    maf_defer #(
        .DEFER_CYC(DEFER_CYC)
    ) u_defer (
        .mclk(mclk),
        .srst(srst),
        .tx_enable(ctrl_q[`MAF_CTRL_TX_EN]), // R4
        .defer_check(ctrl_q[`MAF_CTRL_DEFER_CHK]), // R1 R3
        .tx_req(tx_req),
        .medium_busy(medium_busy),
        .backoff_done(backoff_done),
        .tx_done(tx_done),
        .tx_start(tx_start),
        .deferring(deferring),
        .defer_timeout(defer_timeout)
    );

    // receive address filter
    maf_hash u_hash (
        .mclk(mclk),
        .srst(srst),
        .rx_enable(ctrl_q[`MAF_CTRL_RX_EN]), // R5
        .pass_all_multicast(ctrl_q[`MAF_CTRL_PASS_MC]), // R14
        .station_addr({addr_hi_q, addr_lo_q}), // R10
        .hash_table({hash_hi_q, hash_lo_q}), // R15
        .rx_sof(rx_sof),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rx_accept(rx_accept),
        .rx_reject(rx_reject)
    );

endmodule // maf_top

// file: testbench/maf_port_monitor.sv
// port checker of the address filter block
module maf_port_monitor
    import maf_pkg::*;
#(
    parameter int DEFER_CYC = 20
) (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // loader and transmit
    input wire logic ee_done,
    input wire logic tx_req,
    input wire logic tx_start,
    // receive and state
    input wire logic rx_valid,
    input wire logic rx_accept,
    input wire logic rx_reject,
    input wire logic init_done
);
    timeunit 1ns;
    timeprecision 1ps;
    // one clock domain
    default clocking mon_cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside answer cycle");
    hi_reserved_a: assert property ($past(reg_rd) && $past(reg_addr) == 4'h2
        |-> reg_rdata[31:16] == 16'h0) else $error("reserved high half nonzero");
    start_pulse_a: assert property (tx_start |=> !tx_start)
        else $error("start longer than one cycle");
    start_cause_a: assert property (tx_start |-> $past(tx_req))
        else $error("start without request");
    verdict_excl_a: assert property (!(rx_accept && rx_reject))
        else $error("accept and reject together");
    verdict_pulse_a: assert property ((rx_accept || rx_reject)
        |=> !(rx_accept || rx_reject)) else $error("verdict too long");
    verdict_cause_a: assert property ((rx_accept || rx_reject) |-> $past(rx_valid))
        else $error("verdict without byte");
    init_sticky_a: assert property (init_done |=> init_done)
        else $error("init done dropped");
    init_cause_a: assert property ($rose(init_done)
        |-> $past(ee_done) || $past(ee_done, 2)) else $error("init without load end");
endmodule // maf_port_monitor

bind maf_top maf_port_monitor #(.DEFER_CYC(DEFER_CYC)) u_mon (.mclk(mclk), .srst(srst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ee_done(ee_done),
    .tx_req(tx_req), .tx_start(tx_start), .rx_valid(rx_valid), .rx_accept(rx_accept),
    .rx_reject(rx_reject), .init_done(init_done));

// file: testbench/maf_net_model.sv
// network side model sending a destination address
module maf_net_model (
    // clock and start
    input wire logic mclk,
    input wire logic go,
    input wire logic [47:0] da,
    // byte stream toward the filter
    output logic rx_sof,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int k = 6;
    // idle line at time zero
    initial
    begin
        rx_sof = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    // one byte a cycle, address bits 7:0 first, data toggles when released
    always @(posedge mclk)
    begin
        if (go || k < 6)
        begin
            rx_sof <= go;
            rx_valid <= 1'b1;
            rx_data <= da[8 * (go ? 0 : k) +: 8];
            k <= go ? 1 : k + 1;
        end
        else
        begin
            rx_sof <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
        end
    end
endmodule // maf_net_model

// file: testbench/test_mac_address_filter_config.sv
// register, loader, filter and deferral tests of the filter block
`include "maf_defs.svh"
module test_mac_address_filter_config;
    timeunit 1ns;
    timeprecision 1ps;
    import maf_pkg::*;
    localparam int DC = 20;
    localparam logic [47:0] SA = 48'hBC9A_7856_3412;
    localparam logic [47:0] ST = 48'hCCAB_7856_3412;
    localparam logic [47:0] MC = 48'h0000_0000_0001;
    logic mclk, srst, reg_wr, reg_rd, ee_present, ee_valid, ee_done, go;
    logic tx_req, medium_busy, backoff_done, tx_done, tx_start;
    logic rx_sof, rx_valid, rx_accept, rx_reject, init_done;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [7:0] ee_addr, ee_data, rx_data;
    logic [47:0] da;
    logic [5:0] ix;
    logic [1:0] got;
    int err_total = 0, samples_checked = 0, cyc = 0, n_st = 0, k;

    maf_top #(.DEFER_CYC(DC)) u_dut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ee_present(ee_present), .ee_valid(ee_valid), .ee_addr(ee_addr),
        .ee_data(ee_data), .ee_done(ee_done), .tx_req(tx_req),
        .medium_busy(medium_busy), .backoff_done(backoff_done), .tx_done(tx_done),
        .tx_start(tx_start), .rx_sof(rx_sof), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_accept(rx_accept), .rx_reject(rx_reject), .init_done(init_done));
    maf_net_model u_net (.mclk(mclk), .go(go), .da(da), .rx_sof(rx_sof),
        .rx_valid(rx_valid), .rx_data(rx_data));

    // clock
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // verdict and start capture, hang guard
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (rx_accept === 1'b1) got[1] <= 1'b1;
        if (rx_reject === 1'b1) got[0] <= 1'b1;
        if (tx_start === 1'b1) n_st <= n_st + 1;
        if (cyc == 5000)
        begin
            err_total++;
            results();
        end
    end

    task automatic results();
        if (err_total == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
        @(posedge mclk);
    endtask

    task automatic ee(input logic [7:0] a, input logic [7:0] d);
        ee_addr <= a;
        ee_data <= d;
        ee_valid <= 1'b1;
        @(posedge mclk);
        ee_valid <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic frame(input logic [47:0] d, input logic [1:0] exp);
        got = 2'b00;
        da <= d;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (10) @(posedge mclk);
        chk({30'h0, got}, {30'h0, exp});
    endtask

    // cycles until start, judged on the falling edge
    task automatic wstart(input int lo, input int hi);
        int n;
        n = 0;
        while (tx_start !== 1'b1 && n <= hi)
        begin
            @(negedge mclk);
            n++;
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
        @(posedge mclk);
    endtask

    // reflected crc over the address, top six bits
    function automatic logic [5:0] hidx(input logic [47:0] d);
        logic [31:0] c;
        c = `MAF_CRC_INIT;
        for (int i = 0; i < 48; i++)
            c = (c[0] ^ d[i]) ? (c >> 1) ^ `MAF_CRC_POLY : c >> 1;
        return c[31:26];
    endfunction

    // main sequence
    initial
    begin
        {reg_wr, reg_rd, ee_present, ee_valid, ee_done, go} = 6'h0;
        {tx_req, medium_busy, backoff_done, tx_done} = 4'h0;
        {reg_addr, reg_wdata, ee_addr, ee_data, da} = '0;
        srst = 1'b1;
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rd(4'h2, 32'h0000FFFF);
        rd(4'h3, 32'h0FFFFFFF);
        rd(4'h4, 32'h0);
        rd(4'h5, 32'h0);
        rd(4'h6, 32'h0);
        rd(4'h1, 32'h4);
        ee_present <= 1'b1;
        for (int i = 1; i <= 6; i++)
            ee(8'(i), SA[8 * (i - 1) +: 8]);
        ee_done <= 1'b1;
        @(posedge mclk);
        ee_done <= 1'b0;
        @(posedge mclk);
        chk({31'h0, init_done}, 32'h1);
        rd(4'h3, 32'h78563412);
        rd(4'h2, 32'h0000BC9A);
        ee(8'h01, 8'h55);
        rd(4'h3, 32'h78563412);
        wr(4'h2, 32'hFFFF_CCAB);
        rd(4'h2, 32'h0000CCAB);
        frame(ST, 2'b00);
        wr(4'h1, 32'h1);
        frame(ST, 2'b10);
        frame(48'h1234_5678_ABCC, 2'b01);
        ix = hidx(MC);
        frame(MC, 2'b01);
        wr(ix[5] ? 4'h5 : 4'h4, 32'h1 << ix[4:0]);
        frame(MC, 2'b01);
        wr(ix[5] ? 4'h4 : 4'h5, 32'h1 << ix[4:0]);
        frame(MC, 2'b10);
        wr(4'h4, 32'h0);
        wr(4'h5, 32'h0);
        wr(4'h1, 32'h9);
        frame(MC, 2'b10);
        tx_req <= 1'b1;
        medium_busy <= 1'b1;
        repeat (DC + 10) @(posedge mclk);
        chk(32'(n_st), 32'h0);
        wr(4'h1, 32'h7);
        wstart(DC - 4, DC + 4);
        backoff_done <= 1'b1;
        @(posedge mclk);
        backoff_done <= 1'b0;
        wstart(DC - 4, DC + 4);
        tx_done <= 1'b1;
        @(posedge mclk);
        tx_done <= 1'b0;
        wr(4'h1, 32'h3);
        k = n_st;
        repeat (3 * DC) @(posedge mclk);
        chk(32'(n_st - k), 32'h0);
        rd(4'h9, 32'h7);
        wr(4'h9, 32'h4);
        rd(4'h9, 32'h3);
        medium_busy <= 1'b0;
        wstart(0, 4);
        results();
    end
endmodule // test_mac_address_filter_config
